/* rtl/mmdec_pkg.sv */
package mmdec_pkg;

  // operating modes, sampled from the mode strap once after reset
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_EXPANDED,
    MODE_BOOT,
    MODE_TEST
  } mmdec_mode_type;

  // register offsets on the AXI4-Lite bus (byte addresses)
  localparam logic [7:0] OFF_MAP    = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  // mapping register
  localparam logic [7:0] MAP_RESET      = 8'h01;
  localparam int         MAP_RAM_LSB    = 4;
  localparam int         MAP_REG_LSB    = 0;
  localparam logic [6:0] MAP_WINDOW_CYC = 7'h40;

  // configuration register: eeprom_on at bit 0, eeprom page at bits 7:4
  localparam int         CFG_EEPROM_ON_BIT = 0;
  localparam int         CFG_PAGE_LSB = 4;
  localparam logic [7:0] CFG_RESET    = 8'hF1;

  // status register fields
  localparam int STS_WRITTEN_BIT = 0;
  localparam int STS_WINDOW_BIT  = 1;
  localparam int STS_MODE_LSB    = 2;
  localparam int STS_COUNT_LSB   = 8;

  // region sizes and fixed locations
  localparam logic [11:0] RAM_SIZE       = 12'h400;
  localparam logic [11:0] REGBLK_SIZE    = 12'h060;
  localparam logic [11:0] REGBLK_MAP_OFF = 12'h03D;
  localparam logic [3:0]  EE_FIXED_PAGE  = 4'hF;
  localparam logic [2:0]  EE_OFF_TOP     = 3'h7;
  localparam logic [7:0]  BOOT_HI        = 8'hBF;

  // unused locations inside the register block
  localparam logic [11:0] REGBLK_RSV0_LO = 12'h036;
  localparam logic [11:0] REGBLK_RSV0_HI = 12'h037;
  localparam logic [11:0] REGBLK_RSV1_LO = 12'h040;
  localparam logic [11:0] REGBLK_RSV1_HI = 12'h05B;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* rtl/mmdec_top.sv */
// Behaviour
// [R1] every 64K address not claimed internally selects the external bus
// [R2] 1K RAM sits on any 4K page chosen by the mapping register
// [R3] 96-byte register block on any 4K page, page 1 after reset
// [R4] reset map: RAM 0000-03FF, register block 1000-105F
// [R5] EEPROM answers only while eeprom_on is set
// [R6] expanded/test: EEPROM at offsets E00-FFF of configured page
// [R7] single-chip/bootstrap: EEPROM fixed at FE00-FFFF
// [R8] boot ROM at BF00-BFFF in bootstrap mode only
// [R9] register block beats RAM, boot ROM beats EEPROM
// [R10] RAM and register pages independent; hidden RAM simply unreachable
// [R11] normal modes: one map write, only within 64 cycles of reset
// [R12] reset loads mapping register with 01
// [R13] map bits 7:4 give the RAM page
// [R14] map bits 3:0 give the register block page
// [R15] page field forms address bits 15:12, low 12 bits are offset
// [R16] internal hit blocks external read data from the internal bus
// [R17] unused register block locations read undriven, no other source
// [R18] special modes bypass the write-once protection
// [R19] exactly one select is active for every address
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module mmdec_top
  import mmdec_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // mode strap
  input  wire logic [1:0]  mode_in,
  // cpu internal bus
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic        cpu_rd_in,
  input  wire logic        cpu_wr_in,
  input  wire logic [7:0]  cpu_wdata_in,
  // region selects
  output logic             ram_sel_out,
  output logic             regblk_sel_out,
  output logic             eeprom_sel_out,
  output logic             bootrom_sel_out,
  output logic             ext_sel_out,
  output logic             ext_data_en_out,
  output logic             regblk_unused_out,
  output logic [11:0]      offset_out,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  function automatic logic page_hit(input logic [15:0] addr, input logic [3:0] page,
                                    input logic [11:0] size);
    page_hit = (addr[15:12] == page) && (addr[11:0] < size);
  endfunction

  function automatic logic known_off(input logic [7:0] off);
    known_off = (off == OFF_MAP) || (off == OFF_CONFIG) || (off == OFF_STATUS);
  endfunction

  logic [7:0]     map_reg;
  logic [7:0]     cfg_reg;
  logic           map_written;
  logic [6:0]     e_count;
  mmdec_mode_type mode;
  logic           mode_taken;

  logic           aw_held;
  logic [7:0]     aw_addr;
  logic           w_held;
  logic [31:0]    w_data;
  logic [3:0]     w_strb;

  // mode and page decode
  wire logic       special   = (mode == MODE_BOOT) || (mode == MODE_TEST);
  wire logic       fixed_ee  = (mode == MODE_SINGLE) || (mode == MODE_BOOT);
  wire logic       window    = (e_count < MAP_WINDOW_CYC);
  wire logic [3:0] ram_page  = map_reg[MAP_RAM_LSB +: 4];
  wire logic [3:0] reg_page  = map_reg[MAP_REG_LSB +: 4];
  wire logic       eeprom_on = cfg_reg[CFG_EEPROM_ON_BIT];
  wire logic [3:0] ee_page   = fixed_ee ? EE_FIXED_PAGE : cfg_reg[CFG_PAGE_LSB +: 4];

  // region hits before priority
  wire logic reg_hit  = page_hit(cpu_addr_in, reg_page, REGBLK_SIZE);
  wire logic ram_hit  = page_hit(cpu_addr_in, ram_page, RAM_SIZE);
  wire logic boot_hit = (mode == MODE_BOOT) && (cpu_addr_in[15:8] == BOOT_HI);
  wire logic ee_hit   = eeprom_on && (cpu_addr_in[15:12] == ee_page)
                        && (cpu_addr_in[11:9] == EE_OFF_TOP);

  // priority: register block, RAM, boot ROM, EEPROM, external
  wire logic next_reg  = reg_hit;                                   // [R3] [R9]
  wire logic next_ram  = ram_hit && !reg_hit;                       // [R2] [R10]
  wire logic next_boot = boot_hit && !reg_hit && !ram_hit;          // [R8]
  wire logic next_ee   = ee_hit && !boot_hit && !reg_hit && !ram_hit; // [R5] [R6] [R7] [R9]
  wire logic next_ext  = !(reg_hit || ram_hit || boot_hit || ee_hit); // [R1] [R19]

  wire logic [11:0] reg_off     = cpu_addr_in[11:0];                // [R15]
  wire logic        next_unused = reg_hit &&
      (((reg_off >= REGBLK_RSV0_LO) && (reg_off <= REGBLK_RSV0_HI)) ||
       ((reg_off >= REGBLK_RSV1_LO) && (reg_off <= REGBLK_RSV1_HI))); // [R17]

  // mapping register write sources and protection
  wire logic aw_take   = s_axi_awvalid && s_axi_awready;
  wire logic w_take    = s_axi_wvalid && s_axi_wready;
  wire logic wr_fire   = aw_held && w_held && !s_axi_bvalid;
  wire logic axi_map   = wr_fire && (aw_addr == OFF_MAP) && w_strb[0];
  wire logic axi_cfg   = wr_fire && (aw_addr == OFF_CONFIG) && w_strb[0];
  wire logic cpu_map   = cpu_wr_in && reg_hit && (reg_off == REGBLK_MAP_OFF);
  wire logic map_req   = axi_map || cpu_map;
  wire logic map_allow = special || (window && !map_written);       // [R11] [R18]
  wire logic map_load  = map_req && map_allow;
  wire logic [7:0] next_map = axi_map ? w_data[7:0] : cpu_wdata_in;
  wire logic wr_known  = known_off(aw_addr);

  // read decode
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic [31:0] status_word =
      (32'(map_written) << STS_WRITTEN_BIT) | (32'(window) << STS_WINDOW_BIT)
      | (32'(mode) << STS_MODE_LSB) | (32'(e_count) << STS_COUNT_LSB);
  wire logic [31:0] next_rdata =
      (s_axi_araddr == OFF_MAP)    ? {24'h000000, map_reg} :
      (s_axi_araddr == OFF_CONFIG) ? {24'h000000, cfg_reg} :
      (s_axi_araddr == OFF_STATUS) ? status_word : 32'h00000000;
  wire logic rd_known = known_off(s_axi_araddr);

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // mode strap caught once after reset release
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode       <= MODE_SINGLE;
      mode_taken <= 1'b0;
    end else if (!mode_taken) begin
      mode       <= mmdec_mode_type'(mode_in);
      mode_taken <= 1'b1;
    end
  end

  // cycle count since reset, saturating at the window length
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      e_count <= 7'h00;
    end else if (window) begin
      e_count <= e_count + 7'h01;                                   // [R11]
    end
  end

  // mapping and configuration registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      map_reg     <= MAP_RESET;                                     // [R4] [R12]
      map_written <= 1'b0;
      cfg_reg     <= CFG_RESET;
    end else begin
      if (map_load) begin
        map_reg <= next_map;                                        // [R13] [R14]
      end
      if (map_req) begin
        map_written <= map_written || map_allow;                    // [R11]
      end
      if (axi_cfg) begin
        cfg_reg <= w_data[7:0];
      end
    end
  end

  // registered selects
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ram_sel_out       <= 1'b0;
      regblk_sel_out    <= 1'b0;
      eeprom_sel_out    <= 1'b0;
      bootrom_sel_out   <= 1'b0;
      ext_sel_out       <= 1'b1;
      ext_data_en_out   <= 1'b0;
      regblk_unused_out <= 1'b0;
      offset_out        <= 12'h000;
    end else begin
      ram_sel_out       <= next_ram;
      regblk_sel_out    <= next_reg;
      eeprom_sel_out    <= next_ee;
      bootrom_sel_out   <= next_boot;
      ext_sel_out       <= next_ext;
      ext_data_en_out   <= next_ext && cpu_rd_in;                   // [R16]
      regblk_unused_out <= next_unused;                             // [R17]
      offset_out        <= reg_off;                                 // [R15]
    end
  end

  // axi write channels
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  sel_onehot_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R19]
    $onehot({ram_sel_out, regblk_sel_out, eeprom_sel_out, bootrom_sel_out, ext_sel_out}))
    else $error("selects not one-hot");

  map_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R12]
    !map_written |-> (map_reg == MAP_RESET))
    else $error("mapping register left reset value without a write");

  map_window_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R11]
    (!special && !window) |=> $stable(map_reg))
    else $error("mapping register changed after the window");

  map_once_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R11]
    (!special && map_written) |=> $stable(map_reg))
    else $error("mapping register written twice");

  special_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R18]
    (special && axi_map) |=> (map_reg == $past(w_data[7:0])))
    else $error("special mode map write not taken");

  window_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R11]
    $fell(window) |-> ($past(e_count) == (MAP_WINDOW_CYC - 7'h01)))
    else $error("write window length wrong");

  reg_prio_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R9]
    (reg_hit && ram_hit) |=> (regblk_sel_out && !ram_sel_out))
    else $error("RAM won over register block");

  boot_only_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R8]
    (mode != MODE_BOOT) |=> !bootrom_sel_out)
    else $error("boot ROM selected outside bootstrap mode");

  ee_enable_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R5]
    !eeprom_on |=> !eeprom_sel_out)
    else $error("EEPROM selected while disabled");

  ee_fixed_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R7]
    (fixed_ee && eeprom_on && (cpu_addr_in[15:9] == {EE_FIXED_PAGE, EE_OFF_TOP})
     && !reg_hit && !ram_hit && !boot_hit) |=> eeprom_sel_out)
    else $error("EEPROM missing at FE00-FFFF");

  ext_block_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R16]
    (cpu_rd_in && !next_ext) |=> (!ext_data_en_out && !ext_sel_out))
    else $error("external data enabled on internal hit");

  ram_page_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R2] [R13]
    ((cpu_addr_in[15:12] == map_reg[MAP_RAM_LSB +: 4]) && (cpu_addr_in[11:0] < RAM_SIZE)
     && !reg_hit) |=> ram_sel_out)
    else $error("RAM missing on its page");

  ram_end_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R2]
    (cpu_addr_in[11:0] >= RAM_SIZE) |=> !ram_sel_out)
    else $error("RAM selected past its 1K size");

  reg_page_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R3] [R14]
    ((cpu_addr_in[15:12] == map_reg[MAP_REG_LSB +: 4]) && (cpu_addr_in[11:0] < REGBLK_SIZE))
    |=> regblk_sel_out)
    else $error("register block missing on its page");

  reg_end_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R3]
    (cpu_addr_in[11:0] >= REGBLK_SIZE) |=> !regblk_sel_out)
    else $error("register block selected past 96 bytes");

  offset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R15]
    1'b1 |=> (offset_out == $past(cpu_addr_in[11:0])))
    else $error("offset is not the low twelve address bits");

  ext_free_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R1]
    (!eeprom_on && (mode != MODE_BOOT) && !reg_hit && !ram_hit) |=> ext_sel_out)
    else $error("unclaimed address not given to the external bus");

  ee_page_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R6]
    (!fixed_ee && (cpu_addr_in[15:12] != cfg_reg[CFG_PAGE_LSB +: 4])) |=> !eeprom_sel_out)
    else $error("EEPROM selected off its configured page");

  ee_fix_page_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R7]
    (fixed_ee && (cpu_addr_in[15:12] != EE_FIXED_PAGE)) |=> !eeprom_sel_out)
    else $error("EEPROM selected off the top page");

  boot_addr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R8]
    (cpu_addr_in[15:8] != BOOT_HI) |=> !bootrom_sel_out)
    else $error("boot ROM selected outside its 256 bytes");

  ext_data_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R16]
    ext_data_en_out |-> ext_sel_out)
    else $error("external data enabled without external select");

  unused_in_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R17]
    regblk_unused_out |-> regblk_sel_out)
    else $error("unused flag raised outside the register block");

  written_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R11]
    map_written |=> map_written)
    else $error("write-once flag cleared without reset");

  cpu_special_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R18]
    (special && cpu_map && !axi_map) |=> (map_reg == $past(cpu_wdata_in)))
    else $error("special mode cpu map write not taken");

endmodule

/* tb/mmdec_cpu_model.sv */
`timescale 1ns/100ps
module mmdec_cpu_model (
  // clock
  input  wire logic sys_clk_in,
  // cpu internal bus
  output logic [15:0] cpu_addr_out,
  output logic        cpu_rd_out,
  output logic        cpu_wr_out,
  output logic [7:0]  cpu_wdata_out
);
  initial begin
    cpu_addr_out  = 16'h0000;
    cpu_rd_out    = 1'b0;
    cpu_wr_out    = 1'b0;
    cpu_wdata_out = 8'h00;
  end
  // one bus cycle, changed just after an edge; data flips when not writing
  task automatic drive(input logic [15:0] a, input logic r, input logic w, input logic [7:0] d);
    @(posedge sys_clk_in);
    cpu_addr_out  <= a;
    cpu_rd_out    <= r;
    cpu_wr_out    <= w;
    cpu_wdata_out <= w ? d : ~cpu_wdata_out;
  endtask
endmodule

/* tb/memory_map_decoder_bench.sv */
`timescale 1ns/100ps
module memory_map_decoder_bench
  import mmdec_pkg::*;
();
  localparam logic [4:0] S_RAM = 5'h10;
  localparam logic [4:0] S_REG = 5'h08;
  localparam logic [4:0] S_EE  = 5'h04;
  localparam logic [4:0] S_BT  = 5'h02;
  localparam logic [4:0] S_EXT = 5'h01;
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [1:0]  mode_in = 2'h1;
  logic [15:0] cpu_addr_in;
  logic        cpu_rd_in, cpu_wr_in;
  logic [7:0]  cpu_wdata_in;
  logic        ram_sel_out, regblk_sel_out, eeprom_sel_out, bootrom_sel_out, ext_sel_out;
  logic        ext_data_en_out, regblk_unused_out;
  logic [11:0] offset_out;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  mmdec_cpu_model i_cpu (.sys_clk_in, .cpu_addr_out(cpu_addr_in), .cpu_rd_out(cpu_rd_in),
    .cpu_wr_out(cpu_wr_in), .cpu_wdata_out(cpu_wdata_in));
  mmdec_top i_dut (.sys_clk_in, .rst_n_in, .mode_in, .cpu_addr_in, .cpu_rd_in, .cpu_wr_in,
    .cpu_wdata_in, .ram_sel_out, .regblk_sel_out, .eeprom_sel_out, .bootrom_sel_out,
    .ext_sel_out, .ext_data_en_out, .regblk_unused_out, .offset_out, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  always #5 sys_clk_in = ~sys_clk_in;

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    mode_in  <= m;
    repeat (12) @(posedge sys_clk_in);
    chk({27'h0, ram_sel_out, regblk_sel_out, eeprom_sel_out, bootrom_sel_out, ext_sel_out},
      {27'h0, S_EXT});
    rst_n_in <= 1'b1;
  endtask

  task automatic dec(input logic [15:0] a, input logic [4:0] e);
    i_cpu.drive(a, 1'b1, 1'b0, 8'h00);
    @(posedge sys_clk_in);
    #1;
    chk({26'h0, ext_data_en_out, ram_sel_out, regblk_sel_out, eeprom_sel_out,
      bootrom_sel_out, ext_sel_out}, {26'h0, e == S_EXT, e});
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge sys_clk_in);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar;
    ar = 1'b1;
    @(posedge sys_clk_in);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (ar && s_axi_arready === 1'b1) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  initial begin
    do_reset(2'h1);
    axi_rd(OFF_MAP, 32'h01, RESP_OKAY);
    axi_wr(OFF_MAP, 32'h23);
    axi_rd(OFF_MAP, 32'h23, RESP_OKAY);
    dec(16'h2000, S_RAM);
    dec(16'h23FF, S_RAM);
    dec(16'h2400, S_EXT);
    dec(16'h3000, S_REG);
    dec(16'h1000, S_EXT);
    axi_wr(OFF_MAP, 32'h45);
    axi_rd(OFF_MAP, 32'h23, RESP_OKAY);
    dec(16'hFE00, S_EE);
    axi_wr(OFF_CONFIG, 32'h50);
    dec(16'h5E00, S_EXT);
    axi_wr(OFF_CONFIG, 32'h51);
    dec(16'h5E00, S_EE);
    dec(16'h5FFF, S_EE);
    dec(16'h5DFF, S_EXT);
    dec(16'hBF00, S_EXT);
    axi_rd(8'h0C, 32'h0, RESP_SLVERR);
    $display("test expanded done");
    do_reset(2'h0);
    axi_rd(OFF_CONFIG, 32'hF1, RESP_OKAY);
    dec(16'h0000, S_RAM);
    dec(16'h03FF, S_RAM);
    dec(16'h0400, S_EXT);
    dec(16'h1000, S_REG);
    dec(16'h105F, S_REG);
    chk({20'h0, offset_out}, 32'h05F);
    dec(16'h1060, S_EXT);
    dec(16'h1036, S_REG);
    chk({31'h0, regblk_unused_out}, 32'h1);
    dec(16'h1035, S_REG);
    chk({31'h0, regblk_unused_out}, 32'h0);
    dec(16'hBF00, S_EXT);
    repeat (64) @(posedge sys_clk_in);
    axi_wr(OFF_MAP, 32'h23);
    axi_rd(OFF_MAP, 32'h01, RESP_OKAY);
    axi_rd(OFF_STATUS, 32'h00004000, RESP_OKAY);
    axi_wr(OFF_CONFIG, 32'h51);
    dec(16'hFE00, S_EE);
    dec(16'h5E00, S_EXT);
    $display("test single done");
    do_reset(2'h2);
    axi_wr(OFF_MAP, 32'h11);
    dec(16'h1000, S_REG);
    dec(16'h1060, S_RAM);
    dec(16'h13FF, S_RAM);
    dec(16'hBF00, S_BT);
    dec(16'hBEFF, S_EXT);
    dec(16'hFE00, S_EE);
    axi_wr(OFF_MAP, 32'h00);
    axi_rd(OFF_MAP, 32'h00, RESP_OKAY);
    dec(16'h0000, S_REG);
    i_cpu.drive(16'h003D, 1'b0, 1'b1, 8'h22);
    i_cpu.drive(16'h0000, 1'b0, 1'b0, 8'h00);
    axi_rd(OFF_MAP, 32'h22, RESP_OKAY);
    $display("test bootstrap done");
    do_reset(2'h3);
    axi_wr(OFF_CONFIG, 32'h31);
    dec(16'h3E00, S_EE);
    dec(16'hFE00, S_EXT);
    repeat (70) @(posedge sys_clk_in);
    axi_wr(OFF_MAP, 32'h45);
    axi_rd(OFF_MAP, 32'h45, RESP_OKAY);
    $display("test special done");
    complete_run();
  end
endmodule
